/* occ_defs.vh */
// register offsets, field positions, reset values and timing counts for the oscillator control block
`ifndef OCC_DEFS_VH
`define OCC_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OCC_ADDR_IRQ_ENABLE   8'h0C
`define OCC_ADDR_IRQ_FLAG     8'h10
`define OCC_ADDR_IRQ_CLEAR    8'h14
`define OCC_ADDR_FAST_CTRL    8'h18
`define OCC_ADDR_EXT_CTRL     8'h1C
`define OCC_ADDR_SLOW_CTRL    8'h20

// ****************************************************************
// field positions
// ****************************************************************
`define OCC_KEY_MSB           31
`define OCC_KEY_LSB           16
`define OCC_KEY_VALUE         16'h5A5A
`define OCC_IRQ_FAST_BIT      0
`define OCC_IRQ_EXT_BIT       1
`define OCC_IRQ_SLOW_BIT      3
`define OCC_FAST_STABLE_BIT   15
`define OCC_FAST_DIV_MSB      14
`define OCC_FAST_DIV_LSB      11
`define OCC_FAST_TRIM_MSB     10
`define OCC_SLOW_STABLE_BIT   15
`define OCC_SLOW_WAIT_MSB     11
`define OCC_SLOW_WAIT_LSB     10
`define OCC_SLOW_TRIM_MSB     9
`define OCC_EXT_STABLE_BIT    19
`define OCC_EXT_SEL_BIT       7
`define OCC_EXT_GATE_BIT      6
`define OCC_ISR_SLOW_ST_BIT   14
`define OCC_ISR_EXT_ST_BIT    12
`define OCC_ISR_FAST_ST_BIT   11

// ****************************************************************
// reset values
// ****************************************************************
`define OCC_RST_IRQ_ENABLE    4'h0
`define OCC_RST_FAST_DIV      4'h5
`define OCC_RST_FAST_TRIM     11'h400
`define OCC_RST_SLOW_WAIT     2'h0
`define OCC_RST_SLOW_TRIM     10'h200
`define OCC_RST_EXT_CTRL      32'h0007FF22
`define OCC_IRQ_CLEAR_READ    32'h0000000B

// ****************************************************************
// slow oscillator settle counts in slow clock cycles
// ****************************************************************
`define OCC_SETTLE_0          9'h006
`define OCC_SETTLE_1          9'h012
`define OCC_SETTLE_2          9'h042
`define OCC_SETTLE_3          9'h102

`endif

/* occ_regs.v */
// oscillator control and status registers behind an avalon-mm slave
`timescale 1ns/1ps
`include "occ_defs.vh"

module occ_regs
#(
    parameter FAST_TRIM_W = 11,
    parameter SLOW_TRIM_W = 10
)
(
    input  wire                   ref_clk_i,
    input  wire                   rst_n_i,
    input  wire                   clk_en_i,
    input  wire [7:0]             avs_address_i,
    input  wire                   avs_read_i,
    input  wire                   avs_write_i,
    input  wire [31:0]            avs_writedata_i,
    input  wire [3:0]             avs_byteenable_i,
    output reg  [31:0]            avs_readdata_o,
    output reg                    avs_waitrequest_o,
    input  wire                   fast_osc_ready_i,
    input  wire                   ext_input_clock_ready_i,
    input  wire                   slow_osc_tick_i,
    input  wire                   slow_osc_restart_i,
    input  wire                   ext_pin_first_i,
    input  wire                   ext_pin_second_i,
    output reg  [3:0]             fast_div_code_o,
    output reg  [4:0]             fast_div_ratio_o,
    output reg  [FAST_TRIM_W-1:0] fast_osc_trim_o,
    output reg  [SLOW_TRIM_W-1:0] slow_osc_trim_o,
    output reg                    ext_pin_select_o,
    output reg                    ext_pin_gate_o,
    output reg                    ext_input_clock_o,
    output reg                    slow_osc_stable_o,
    output reg                    clock_irq_o
);

// ****************************************************************
// functions
// ****************************************************************
// division ratio for a divider code; unlisted codes fall back to six,
// the ratio of the reset code, so a stray code never stops the clock
function [4:0] div_ratio;
    input [3:0] code;
    begin
        case (code)
            4'h6:    div_ratio = 5'h01;
            4'h8:    div_ratio = 5'h02;
            4'h9:    div_ratio = 5'h04;
            4'hB:    div_ratio = 5'h08;
            4'hC:    div_ratio = 5'h0A;
            4'hD:    div_ratio = 5'h0C;
            4'hE:    div_ratio = 5'h0E;
            4'hF:    div_ratio = 5'h10;
            default: div_ratio = 5'h06;
        endcase
    end
endfunction

// settle length for a wait select code
// the counter is nine bits so the longest length fits
function [8:0] settle_len;
    input [1:0] sel;
    begin
        case (sel)
            2'h0:    settle_len = `OCC_SETTLE_0;
            2'h1:    settle_len = `OCC_SETTLE_1;
            2'h2:    settle_len = `OCC_SETTLE_2;
            default: settle_len = `OCC_SETTLE_3;
        endcase
    end
endfunction

// ****************************************************************
// bus state
// ****************************************************************
localparam ST_IDLE = 1'b0;
localparam ST_DONE = 1'b1;

// reset pattern of the external clock register; single fields are picked from it
localparam [31:0] EXT_RST  = `OCC_RST_EXT_CTRL;
// enable, flag and clear bits that exist; bit 2 is reserved and stays zero
localparam [3:0]  IRQ_MASK = (4'h1 << `OCC_IRQ_FAST_BIT) | (4'h1 << `OCC_IRQ_EXT_BIT) |
                             (4'h1 << `OCC_IRQ_SLOW_BIT);

// handshake state, register fields and stability history
reg                   bus_state_r;
reg [3:0]             irq_en_r;
reg [3:0]             irq_flag_r;
reg [1:0]             settle_sel_r;
reg [8:0]             settle_cnt_r;
reg                   fast_stable_d_r;
reg                   ext_stable_d_r;
reg                   slow_stable_d_r;
reg                   fast_stable_r;
reg                   ext_stable_r;

// decode of the access presented now
wire                  req_w;
wire                  wr_hit;
wire                  key_ok;
wire [3:0]            rise_w;
wire [3:0]            clr_w;
reg  [31:0]           rd_mux;

assign req_w  = (avs_read_i | avs_write_i) & (bus_state_r == ST_IDLE);
assign wr_hit = avs_write_i & (bus_state_r == ST_IDLE);
assign key_ok = avs_writedata_i[`OCC_KEY_MSB:`OCC_KEY_LSB] == `OCC_KEY_VALUE;

// stability edges set sticky flags, laid out as the enable bits;
// each stable bit is held against a copy one cycle older
assign rise_w[`OCC_IRQ_FAST_BIT] = fast_stable_r & ~fast_stable_d_r;
assign rise_w[`OCC_IRQ_EXT_BIT]  = ext_stable_r & ~ext_stable_d_r;
assign rise_w[2]                 = 1'b0;
assign rise_w[`OCC_IRQ_SLOW_BIT] = slow_osc_stable_o & ~slow_stable_d_r;

// a zero written to a clear bit clears; a one does nothing
assign clr_w = (wr_hit && avs_address_i == `OCC_ADDR_IRQ_CLEAR && avs_byteenable_i[0]) ?
               ~avs_writedata_i[3:0] & IRQ_MASK : 4'h0;

// ****************************************************************
// read mux
// ****************************************************************
always @*
begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
        `OCC_ADDR_IRQ_ENABLE: rd_mux = {28'h0000000, irq_en_r};
        `OCC_ADDR_IRQ_FLAG:
        begin
            rd_mux[3:0]                  = irq_flag_r;
            rd_mux[`OCC_ISR_FAST_ST_BIT] = fast_stable_r;
            rd_mux[`OCC_ISR_EXT_ST_BIT]  = ext_stable_r;
            rd_mux[`OCC_ISR_SLOW_ST_BIT] = slow_osc_stable_o;
        end
        `OCC_ADDR_IRQ_CLEAR:  rd_mux = `OCC_IRQ_CLEAR_READ;
        `OCC_ADDR_FAST_CTRL:
        begin
            rd_mux[`OCC_FAST_STABLE_BIT]                   = fast_stable_r;
            rd_mux[`OCC_FAST_DIV_MSB:`OCC_FAST_DIV_LSB]    = fast_div_code_o;
            rd_mux[FAST_TRIM_W-1:0]                        = fast_osc_trim_o;
        end
        `OCC_ADDR_EXT_CTRL:
        begin
            rd_mux                       = EXT_RST & 32'hFFF7FF3F;
            rd_mux[`OCC_EXT_STABLE_BIT]  = ext_stable_r;
            rd_mux[`OCC_EXT_SEL_BIT]     = ext_pin_select_o;
            rd_mux[`OCC_EXT_GATE_BIT]    = ext_pin_gate_o;
        end
        `OCC_ADDR_SLOW_CTRL:
        begin
            rd_mux[`OCC_SLOW_STABLE_BIT]                   = slow_osc_stable_o;
            rd_mux[`OCC_SLOW_WAIT_MSB:`OCC_SLOW_WAIT_LSB]  = settle_sel_r;
            rd_mux[SLOW_TRIM_W-1:0]                        = slow_osc_trim_o;
        end
        default: rd_mux = 32'h00000000;
    endcase
end

// ****************************************************************
// bus handshake and register writes
// ****************************************************************
// one wait cycle per access: the request is taken with waitrequest high and answered
// with waitrequest low in the next cycle; a write lands at the taking edge, so any
// later read already sees it
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        bus_state_r       <= ST_IDLE;
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o    <= 32'h00000000;
        irq_en_r          <= `OCC_RST_IRQ_ENABLE;
        fast_div_code_o   <= `OCC_RST_FAST_DIV;
        fast_osc_trim_o   <= `OCC_RST_FAST_TRIM;
        slow_osc_trim_o   <= `OCC_RST_SLOW_TRIM;
        settle_sel_r      <= `OCC_RST_SLOW_WAIT;
        ext_pin_select_o  <= EXT_RST[`OCC_EXT_SEL_BIT];
        ext_pin_gate_o    <= EXT_RST[`OCC_EXT_GATE_BIT];
    end
    else if (clk_en_i)
    begin
        case (bus_state_r)
            ST_IDLE:
            begin
                if (req_w)
                begin
                    bus_state_r       <= ST_DONE;
                    avs_waitrequest_o <= 1'b0;
                    avs_readdata_o    <= avs_read_i ? rd_mux : 32'h00000000;
                end
                if (wr_hit)
                begin
                    case (avs_address_i)
                        `OCC_ADDR_IRQ_ENABLE:
                            if (key_ok && avs_byteenable_i == 4'hF)
                                irq_en_r <= avs_writedata_i[3:0] & IRQ_MASK;
                        `OCC_ADDR_FAST_CTRL:
                        begin
                            if (avs_byteenable_i[0])
                                fast_osc_trim_o[7:0] <= avs_writedata_i[7:0];
                            if (avs_byteenable_i[1])
                            begin
                                fast_osc_trim_o[FAST_TRIM_W-1:8] <= avs_writedata_i[FAST_TRIM_W-1:8];
                                fast_div_code_o[0]               <= avs_writedata_i[`OCC_FAST_DIV_LSB];
                                fast_div_code_o[3:1]             <= avs_writedata_i[`OCC_FAST_DIV_MSB:12];
                            end
                        end
                        `OCC_ADDR_SLOW_CTRL:
                        begin
                            if (avs_byteenable_i[0])
                                slow_osc_trim_o[7:0] <= avs_writedata_i[7:0];
                            if (avs_byteenable_i[1])
                            begin
                                slow_osc_trim_o[SLOW_TRIM_W-1:8] <= avs_writedata_i[SLOW_TRIM_W-1:8];
                                settle_sel_r <= avs_writedata_i[`OCC_SLOW_WAIT_MSB:`OCC_SLOW_WAIT_LSB];
                            end
                        end
                        `OCC_ADDR_EXT_CTRL:
                            if (avs_byteenable_i[0])
                            begin
                                ext_pin_select_o <= avs_writedata_i[`OCC_EXT_SEL_BIT];
                                ext_pin_gate_o   <= avs_writedata_i[`OCC_EXT_GATE_BIT];
                            end
                        default: ;
                    endcase
                end
            end
            ST_DONE:
            begin
                bus_state_r       <= ST_IDLE;
                avs_waitrequest_o <= 1'b1;
            end
            default:
            begin
                bus_state_r       <= ST_IDLE;
                avs_waitrequest_o <= 1'b1;
            end
        endcase
    end
end

// ****************************************************************
// clock path outputs
// ****************************************************************
// pin mux and gate are registered, so the external clock path lags the pin by one cycle;
// the ratio follows the divider code one cycle later for the same reason
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        fast_div_ratio_o  <= 5'h06;
        ext_input_clock_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
        fast_div_ratio_o  <= div_ratio(fast_div_code_o);
        ext_input_clock_o <= ext_pin_gate_o &
                             (ext_pin_select_o ? ext_pin_second_i : ext_pin_first_i);
    end
end

// ****************************************************************
// stability tracking
// ****************************************************************
// slow settle counter runs on slow oscillator ticks after a restart;
// the wait select is read live, so a change in mid-count moves the end point
// and software should restart the count after changing it
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        settle_cnt_r      <= 9'h000;
        slow_osc_stable_o <= 1'b0;
        fast_stable_r     <= 1'b0;
        ext_stable_r      <= 1'b0;
        fast_stable_d_r   <= 1'b0;
        ext_stable_d_r    <= 1'b0;
        slow_stable_d_r   <= 1'b0;
    end
    else if (clk_en_i)
    begin
        fast_stable_r   <= fast_osc_ready_i;
        ext_stable_r    <= ext_input_clock_ready_i;
        fast_stable_d_r <= fast_stable_r;
        ext_stable_d_r  <= ext_stable_r;
        slow_stable_d_r <= slow_osc_stable_o;
        if (slow_osc_restart_i)
        begin
            settle_cnt_r      <= 9'h000;
            slow_osc_stable_o <= 1'b0;
        end
        else if (slow_osc_tick_i && !slow_osc_stable_o)
        begin
            if (settle_cnt_r + 9'h001 >= settle_len(settle_sel_r))
                slow_osc_stable_o <= 1'b1;
            settle_cnt_r <= settle_cnt_r + 9'h001;
        end
    end
end

// ****************************************************************
// flags and interrupt request
// ****************************************************************
// a rising edge in the clearing cycle keeps the flag set
// the request is registered, so it follows a flag or enable change one cycle later
always @(posedge ref_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        irq_flag_r  <= 4'h0;
        clock_irq_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
        irq_flag_r  <= (irq_flag_r & ~clr_w) | rise_w;
        clock_irq_o <= |(irq_flag_r & irq_en_r);
    end
end

endmodule // occ_regs

/* occ_osc_model.sv */
// behavioural model of the oscillators and external clock pins
`timescale 1ns/1ps
module occ_osc_model
#(
    parameter FAST_WAIT = 20,
    parameter EXT_WAIT  = 30,
    parameter TICK_DIV  = 4
)
(
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic osc_on_i,
    output wire logic fast_ready_o,
    output wire logic ext_ready_o,
    output logic      slow_tick_o,
    output wire logic pin_first_o,
    output wire logic pin_second_o
);
    logic [15:0] run_cnt_r;

    // run time since start-up; everything stands still while off
    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            run_cnt_r   <= 16'h0000;
            slow_tick_o <= 1'b0;
        end
        else if (osc_on_i)
        begin
            run_cnt_r   <= run_cnt_r + 16'h0001;
            slow_tick_o <= (run_cnt_r % TICK_DIV) == (TICK_DIV - 1);
        end
        else
        begin
            slow_tick_o <= 1'b0;
        end
    end

    // ready levels come late so the unsettled state can be seen
    assign fast_ready_o = run_cnt_r >= FAST_WAIT;
    assign ext_ready_o  = run_cnt_r >= EXT_WAIT;
    // two pin clocks of different rate so a wrong select shows
    assign pin_first_o  = run_cnt_r[1];
    assign pin_second_o = run_cnt_r[2];
endmodule // occ_osc_model

/* occ_regs_chk.sv */
// port-level assertions for the oscillator control registers
`timescale 1ns/1ps
module occ_regs_chk
#(
    parameter FAST_TRIM_W = 11,
    parameter SLOW_TRIM_W = 10
)
(
    input wire logic                   ref_clk_i,
    input wire logic                   rst_n_i,
    input wire logic [7:0]             avs_address_i,
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic                   avs_waitrequest_o,
    input wire logic                   fast_osc_ready_i,
    input wire logic                   ext_input_clock_ready_i,
    input wire logic                   slow_osc_tick_i,
    input wire logic                   ext_pin_first_i,
    input wire logic                   ext_pin_second_i,
    input wire logic [3:0]             fast_div_code_o,
    input wire logic [4:0]             fast_div_ratio_o,
    input wire logic [FAST_TRIM_W-1:0] fast_osc_trim_o,
    input wire logic [SLOW_TRIM_W-1:0] slow_osc_trim_o,
    input wire logic                   ext_pin_select_o,
    input wire logic                   ext_pin_gate_o,
    input wire logic                   ext_input_clock_o,
    input wire logic                   slow_osc_stable_o,
    input wire logic                   clock_irq_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // unlisted codes fall back to divide by six
    function automatic [4:0] ratio_of(input [3:0] c);
        case (c)
            4'h6: ratio_of = 5'h01;
            4'h8: ratio_of = 5'h02;
            4'h9: ratio_of = 5'h04;
            4'hB: ratio_of = 5'h08;
            4'hC: ratio_of = 5'h0A;
            4'hD: ratio_of = 5'h0C;
            4'hE: ratio_of = 5'h0E;
            4'hF: ratio_of = 5'h10;
            default: ratio_of = 5'h06;
        endcase
    endfunction

    // ****************************************************************
    // bus handshake, fields and events
    // ****************************************************************
    a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("access not answered in one cycle");
    a_wait_low_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_div_ratio_map: assert property (fast_div_ratio_o == ratio_of($past(fast_div_code_o)))
        else $error("divider ratio does not follow code");
    a_fast_trim_cause: assert property ($changed(fast_osc_trim_o) |-> $past(avs_write_i) && $past(avs_address_i) == 8'h18)
        else $error("fast trim changed without write");
    a_slow_trim_cause: assert property ($changed(slow_osc_trim_o) |-> $past(avs_write_i) && $past(avs_address_i) == 8'h20)
        else $error("slow trim changed without write");
    a_ext_pin_route: assert property (ext_input_clock_o == $past(ext_pin_gate_o & (ext_pin_select_o ? ext_pin_second_i : ext_pin_first_i)))
        else $error("external clock not routed from selected pin");
    a_gate_blocks_pin: assert property (!ext_pin_gate_o [*2] |-> !ext_input_clock_o)
        else $error("blocked pin reached external clock");
    a_slow_on_tick: assert property ($rose(slow_osc_stable_o) |-> $past(slow_osc_tick_i))
        else $error("slow stable rose without a tick");
    a_irq_has_cause: assert property ($rose(clock_irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2) || $past(fast_osc_ready_i, 3) || $past(ext_input_clock_ready_i, 3) || $past(slow_osc_stable_o, 2))
        else $error("interrupt rose without cause");

    c_irq_rise: cover property ($rose(clock_irq_o));
    c_slow_stable: cover property ($rose(slow_osc_stable_o));
    c_ext_clock: cover property ($rose(ext_input_clock_o));
endmodule // occ_regs_chk

/* testbench.sv */
// self-checking bench for the oscillator control registers
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_n, osc_on, restart, rd, wr, p;
    logic [7:0]  addr;
    logic [31:0] wdata, q, d, seed;
    wire  [31:0] rdata;
    wire         wait_rq, fast_rdy, ext_rdy, tick, pin_a, pin_b, ext_clk, slow_st, irq, psel, pgate;
    wire  [3:0]  div_code;
    wire  [4:0]  div_ratio;
    wire  [10:0] ftrim;
    wire  [9:0]  strim;
    integer      n_mismatch, total_checks, i, n;

    occ_regs uut (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_rq), .fast_osc_ready_i(fast_rdy), .ext_input_clock_ready_i(ext_rdy),
        .slow_osc_tick_i(tick), .slow_osc_restart_i(restart), .ext_pin_first_i(pin_a), .ext_pin_second_i(pin_b),
        .fast_div_code_o(div_code), .fast_div_ratio_o(div_ratio), .fast_osc_trim_o(ftrim), .slow_osc_trim_o(strim),
        .ext_pin_select_o(psel), .ext_pin_gate_o(pgate), .ext_input_clock_o(ext_clk), .slow_osc_stable_o(slow_st),
        .clock_irq_o(irq));
    occ_osc_model osc (.ref_clk_i(clk), .rst_n_i(rst_n), .osc_on_i(osc_on), .fast_ready_o(fast_rdy),
        .ext_ready_o(ext_rdy), .slow_tick_o(tick), .pin_first_o(pin_a), .pin_second_o(pin_b));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // a hang counts as a mismatch
    initial
    begin
        #80000;
        n_mismatch = n_mismatch + 1;
        report_and_stop();
    end

    task automatic report_and_stop;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    task automatic chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // request held until waitrequest is sampled low; no fixed latency assumed
    task automatic bus(input w, input [7:0] a, input [31:0] dv);
        integer k;
        begin
            k = 0;
            @(posedge clk);
            rd <= !w;
            wr <= w;
            addr <= a;
            wdata <= dv;
            do begin @(posedge clk); k = k + 1; end while (wait_rq !== 1'b0 && k < 50);
            q = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
            if (k >= 50)
                chk(32'h0000DEAD, 32'h00000000);
        end
    endtask

    task automatic rdchk(input [7:0] a, input [31:0] exp);
        begin
            bus(1'b0, a, 32'h00000000);
            chk(q, exp);
        end
    endtask

    function automatic [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction

    function automatic [4:0] exp_ratio(input [3:0] c);
        case (c)
            4'h6: exp_ratio = 5'h01;
            4'h8: exp_ratio = 5'h02;
            4'h9: exp_ratio = 5'h04;
            4'hB: exp_ratio = 5'h08;
            4'hC: exp_ratio = 5'h0A;
            4'hD: exp_ratio = 5'h0C;
            4'hE: exp_ratio = 5'h0E;
            4'hF: exp_ratio = 5'h10;
            default: exp_ratio = 5'h06;
        endcase
    endfunction

    function automatic integer settle(input [1:0] s);
        settle = (s == 2'h0) ? 6 : (s == 2'h1) ? 18 : (s == 2'h2) ? 66 : 258;
    endfunction

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        {rst_n, osc_on, restart, rd, wr, addr, wdata} = 0;
        seed = 32'h0000DA66;
        n_mismatch = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'h0C, 32'h00000000);
        rdchk(8'h14, 32'h0000000B);
        rdchk(8'h18, 32'h00002C00);
        rdchk(8'h1C, 32'h0007FF22);
        rdchk(8'h20, 32'h00000200);
        rdchk(8'h40, 32'h00000000);
        bus(1'b1, 8'h0C, 32'h1234000B);
        rdchk(8'h0C, 32'h00000000);
        osc_on <= 1'b1;
        repeat (60) @(posedge clk);
        bus(1'b1, 8'h18, 32'h00002ABC);
        rdchk(8'h18, 32'h0000AABC);
        // every divider code with a random trim
        for (i = 0; i < 16; i = i + 1)
        begin
            seed = xs(seed);
            d = {17'h00000, i[3:0], seed[10:0]};
            bus(1'b1, 8'h18, d);
            rdchk(8'h18, d | 32'h00008000);
            chk({21'h0, ftrim}, {21'h0, d[10:0]});
            repeat (2) @(posedge clk);
            chk({23'h0, div_code, div_ratio}, {23'h0, i[3:0], exp_ratio(i[3:0])});
        end
        // pin select and gate, reserved bits written at their default
        for (i = 0; i < 4; i = i + 1)
        begin
            d = 32'h0007FF22 | {24'h000000, i[1:0], 6'h00};
            bus(1'b1, 8'h1C, d);
            rdchk(8'h1C, d | 32'h00080000);
            chk({30'h0, psel, pgate}, {30'h0, i[1:0]});
            // the routed pin shows one cycle late, and only while the gate is open
            p = i[1] ? pin_b : pin_a;
            repeat (6)
            begin
                @(posedge clk);
                chk({31'h0, ext_clk}, {31'h0, i[0] & p});
                p = i[1] ? pin_b : pin_a;
            end
        end
        bus(1'b1, 8'h20, 32'h00000155);
        // each settle length: still unstable one tick early, stable on the last
        for (i = 3; i >= 0; i = i - 1)
        begin
            seed = xs(seed);
            d = {20'h00000, i[1:0], seed[9:0]};
            bus(1'b1, 8'h20, d);
            while (tick !== 1'b1) @(posedge clk);
            restart <= 1'b1;
            @(posedge clk);
            restart <= 1'b0;
            n = 0;
            while (n < settle(i[1:0]) - 1) begin @(posedge clk); if (tick) n = n + 1; end
            chk({31'h0, slow_st}, 32'h00000000);
            while (n < settle(i[1:0])) begin @(posedge clk); if (tick) n = n + 1; end
            @(posedge clk);
            chk({31'h0, slow_st}, 32'h00000001);
            rdchk(8'h20, d | 32'h00008000);
            chk({22'h0, strim}, {22'h0, d[9:0]});
        end
        // flags, keyed enables and write-zero clearing
        rdchk(8'h10, 32'h0000580B);
        chk({31'h0, irq}, 32'h00000000);
        bus(1'b1, 8'h0C, 32'h5A5A000B);
        rdchk(8'h0C, 32'h0000000B);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001);
        bus(1'b1, 8'h14, 32'h0000000B);
        rdchk(8'h10, 32'h0000580B);
        // each enable bit alone, with the fast flag cleared on its own
        bus(1'b1, 8'h0C, 32'h5A5A0001);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001);
        bus(1'b1, 8'h14, 32'h0000000A);
        rdchk(8'h10, 32'h0000580A);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h00000000);
        bus(1'b1, 8'h0C, 32'h5A5A0002);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001);
        bus(1'b1, 8'h14, 32'h00000000);
        rdchk(8'h10, 32'h00005800);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h00000000);
        bus(1'b1, 8'h0C, 32'h5A5A0008);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        repeat (60) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001);
        rdchk(8'h10, 32'h00005808);
        report_and_stop();
    end
endmodule // testbench

bind occ_regs occ_regs_chk #(.FAST_TRIM_W(FAST_TRIM_W), .SLOW_TRIM_W(SLOW_TRIM_W)) chk_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .fast_osc_ready_i(fast_osc_ready_i),
    .ext_input_clock_ready_i(ext_input_clock_ready_i), .slow_osc_tick_i(slow_osc_tick_i),
    .ext_pin_first_i(ext_pin_first_i), .ext_pin_second_i(ext_pin_second_i), .fast_div_code_o(fast_div_code_o),
    .fast_div_ratio_o(fast_div_ratio_o), .fast_osc_trim_o(fast_osc_trim_o), .slow_osc_trim_o(slow_osc_trim_o),
    .ext_pin_select_o(ext_pin_select_o), .ext_pin_gate_o(ext_pin_gate_o), .ext_input_clock_o(ext_input_clock_o),
    .slow_osc_stable_o(slow_osc_stable_o), .clock_irq_o(clock_irq_o));
